// [rtl/cdp_pkg.sv]
// Package of constants for the CPU / transfer-controller priority control block
package cdp_pkg;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned LVL_W         = 3;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] CPR_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] CFG_ADDR = 4'h4;
    localparam logic [ADDR_W-1:0] STA_ADDR = 4'h8;
    // Field positions of the priority control register
    localparam int unsigned CPCE_BIT      = 7;
    localparam int unsigned XLVL_HI       = 6;
    localparam int unsigned XLVL_LO       = 4;
    localparam int unsigned APSE_BIT      = 3;
    localparam int unsigned CLVL_HI       = 2;
    localparam int unsigned CLVL_LO       = 0;
    localparam logic [7:0]  CPR_RESET     = 8'h00;
    // Mode select field encodings (bits 1:0 of the config register)
    localparam logic [1:0]  MODE_0        = 2'h0;
    localparam logic [1:0]  MODE_2        = 2'h2;
    localparam logic [1:0]  MODE_RESET    = 2'h0;
    localparam logic [LVL_W-1:0] LVL_MIN  = 3'h0;
    localparam logic [LVL_W-1:0] LVL_MAX  = 3'h7;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    typedef enum logic [0:0] {
        CDP_IDLE = 1'b0,
        CDP_RESP = 1'b1
    } cdp_bus_state_t;
endpackage : cdp_pkg

// [rtl/cdp_arbiter.sv]
// Decides whether CPU exception handling wins over a transfer
`timescale 1ns/1ps
module cdp_arbiter
    import cdp_pkg::*;
(
    input  wire logic             ctrl_enable,
    input  wire logic [LVL_W-1:0] cpu_level,
    input  wire logic [LVL_W-1:0] xfer_level,
    output logic      [LVL_W-1:0] eff_cpu_level,
    output logic                  cpu_wins
);
    always_comb begin
        eff_cpu_level = ctrl_enable ? cpu_level : LVL_MIN;
        // Ties go to the transfer so a stalled CPU never starves it
        cpu_wins      = ctrl_enable && (cpu_level > xfer_level);
    end
endmodule : cdp_arbiter

// [rtl/cdp_priority_ctrl.sv]
// CPU / transfer-controller priority control with AXI4-Lite register access
// Summary of operation
// - Enable low: CPU always lowest priority
// - Enable high: CPU priority from level field
// - Transfer priority field bits 6:4, read/write
// - CPU priority field bits 2:0
// - Auto set: CPU field follows interrupt mask
// - Auto off: CPU field changes only by writes
// - Auto on: software writes to CPU field ignored
// - CPU exception may win over transfer
// - Mode 00: single mask bit governs masking
// - Mode 10: 3-bit mask level governs masking
`timescale 1ns/1ps
module cdp_priority_ctrl
    import cdp_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              ccr_mask_bit,
    input  wire logic [LVL_W-1:0]  exr_mask_level,
    output logic      [1:0]        ctrl_mode,
    output logic      [LVL_W-1:0]  xfer_prio_level,
    output logic      [LVL_W-1:0]  cpu_prio_level,
    output logic                   cpu_over_xfer
);
    logic [7:0]        cpr_reg,  cpr_next;
    logic [1:0]        mode_reg, mode_next;
    logic              aw_got_reg, aw_got_next;
    logic              w_got_reg,  w_got_next;
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [DATA_W-1:0] wdata_reg,  wdata_next;
    logic [3:0]        wstrb_reg,  wstrb_next;
    cdp_bus_state_t    wst_reg, wst_next;
    logic [1:0]        bresp_reg, bresp_next;
    cdp_bus_state_t    rst_reg, rst_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [1:0]        rresp_reg, rresp_next;
    logic [LVL_W-1:0]  mask_level;
    logic              wr_fire;
    logic [LVL_W-1:0]  eff_level;
    logic              cpu_wins;

    // Mask source for mirroring depends on control mode
    always_comb begin
        if (mode_reg == MODE_2) begin
            mask_level = exr_mask_level;
        end else begin
            mask_level = ccr_mask_bit ? LVL_MAX : LVL_MIN;
        end
    end

    assign s_axi_awready = (wst_reg == CDP_IDLE) && !aw_got_reg;
    assign s_axi_wready  = (wst_reg == CDP_IDLE) && !w_got_reg;
    assign s_axi_arready = (rst_reg == CDP_IDLE);

    // Write channel: address and data taken in either order
    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next  = w_got_reg;
        awaddr_next = awaddr_reg;
        wdata_next  = wdata_reg;
        wstrb_next  = wstrb_reg;
        wst_next    = wst_reg;
        bresp_next  = bresp_reg;
        wr_fire     = 1'b0;
        case (wst_reg)
            CDP_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_got_next = 1'b1;
                    awaddr_next = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_got_next = 1'b1;
                    wdata_next = s_axi_wdata;
                    wstrb_next = s_axi_wstrb;
                end
                if (aw_got_reg && w_got_reg) begin
                    wr_fire     = 1'b1;
                    aw_got_next = 1'b0;
                    w_got_next  = 1'b0;
                    wst_next    = CDP_RESP;
                    if (awaddr_reg == CPR_ADDR || awaddr_reg == CFG_ADDR || awaddr_reg == STA_ADDR) begin
                        bresp_next = RESP_OKAY;
                    end else begin
                        bresp_next = RESP_SLVERR;
                    end
                end
            end
            CDP_RESP: begin
                if (s_axi_bready) begin
                    wst_next = CDP_IDLE;
                end
            end
            default: wst_next = CDP_IDLE;
        endcase
    end

    // Register contents
    always_comb begin
        cpr_next  = cpr_reg;
        mode_next = mode_reg;
        if (wr_fire && wstrb_reg[0]) begin
            if (awaddr_reg == CPR_ADDR) begin
                cpr_next[CPCE_BIT]        = wdata_reg[CPCE_BIT];
                cpr_next[XLVL_HI:XLVL_LO] = wdata_reg[XLVL_HI:XLVL_LO];
                cpr_next[APSE_BIT]        = wdata_reg[APSE_BIT];
                if (!cpr_reg[APSE_BIT]) begin
                    cpr_next[CLVL_HI:CLVL_LO] = wdata_reg[CLVL_HI:CLVL_LO];
                end
            end else if (awaddr_reg == CFG_ADDR) begin
                // Reserved encodings 01 and 11 are refused; the mode holds
                if (wdata_reg[$bits(mode_reg)-1:0] == MODE_0 || wdata_reg[$bits(mode_reg)-1:0] == MODE_2) begin
                    mode_next = wdata_reg[$bits(mode_reg)-1:0];
                end
            end
        end
        // Mirroring wins over a simultaneous write to the level field
        if (cpr_next[APSE_BIT]) begin
            cpr_next[CLVL_HI:CLVL_LO] = mask_level;
        end
    end

    // Read channel
    always_comb begin
        rst_next   = rst_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        case (rst_reg)
            CDP_IDLE: begin
                if (s_axi_arvalid) begin
                    rst_next   = CDP_RESP;
                    rresp_next = RESP_OKAY;
                    rdata_next = '0;
                    if (s_axi_araddr == CPR_ADDR) begin
                        rdata_next[$bits(cpr_reg)-1:0] = cpr_reg;
                    end else if (s_axi_araddr == CFG_ADDR) begin
                        rdata_next[$bits(mode_reg)-1:0] = mode_reg;
                    end else if (s_axi_araddr == STA_ADDR) begin
                        rdata_next[LVL_W-1:0] = eff_level;
                        rdata_next[LVL_W]     = cpu_wins;
                    end else begin
                        rresp_next = RESP_SLVERR;
                    end
                end
            end
            CDP_RESP: begin
                if (s_axi_rready) begin
                    rst_next = CDP_IDLE;
                end
            end
            default: rst_next = CDP_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpr_reg    <= CPR_RESET;
            mode_reg   <= MODE_RESET;
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
            wst_reg    <= CDP_IDLE;
            bresp_reg  <= RESP_OKAY;
            rst_reg    <= CDP_IDLE;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else begin
            cpr_reg    <= cpr_next;
            mode_reg   <= mode_next;
            aw_got_reg <= aw_got_next;
            w_got_reg  <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg  <= wdata_next;
            wstrb_reg  <= wstrb_next;
            wst_reg    <= wst_next;
            bresp_reg  <= bresp_next;
            rst_reg    <= rst_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    cdp_arbiter u_arb (
        .ctrl_enable   (cpr_reg[CPCE_BIT]),
        .cpu_level     (cpr_reg[CLVL_HI:CLVL_LO]),
        .xfer_level    (cpr_reg[XLVL_HI:XLVL_LO]),
        .eff_cpu_level (eff_level),
        .cpu_wins      (cpu_wins)
    );

    assign s_axi_bvalid    = (wst_reg == CDP_RESP);
    assign s_axi_bresp     = bresp_reg;
    assign s_axi_rvalid    = (rst_reg == CDP_RESP);
    assign s_axi_rdata     = rdata_reg;
    assign s_axi_rresp     = rresp_reg;
    assign ctrl_mode       = mode_reg;
    assign xfer_prio_level = cpr_reg[XLVL_HI:XLVL_LO];
    assign cpu_prio_level  = eff_level;
    assign cpu_over_xfer   = cpu_wins;

    property p_lowest_when_off;
        @(posedge aclk) disable iff (!aresetn)
        !cpr_reg[CPCE_BIT] |-> (cpu_prio_level == LVL_MIN) && !cpu_over_xfer;
    endproperty
    a_lowest_when_off: assert property (p_lowest_when_off) else $error("CPU not lowest while disabled");

    property p_level_when_on;
        @(posedge aclk) disable iff (!aresetn)
        cpr_reg[CPCE_BIT] |-> cpu_prio_level == cpr_reg[CLVL_HI:CLVL_LO];
    endproperty
    a_level_when_on: assert property (p_level_when_on) else $error("CPU level not from field");

    sequence s_cpr_write;
        wr_fire && wstrb_reg[0] && awaddr_reg == CPR_ADDR;
    endsequence

    property p_xfer_write;
        @(posedge aclk) disable iff (!aresetn)
        s_cpr_write |=> xfer_prio_level == $past(wdata_reg[XLVL_HI:XLVL_LO]);
    endproperty
    a_xfer_write: assert property (p_xfer_write) else $error("Transfer level write lost");

    property p_cpu_write;
        @(posedge aclk) disable iff (!aresetn)
        s_cpr_write and !cpr_reg[APSE_BIT] and !wdata_reg[APSE_BIT]
            |=> cpr_reg[CLVL_HI:CLVL_LO] == $past(wdata_reg[CLVL_HI:CLVL_LO]);
    endproperty
    a_cpu_write: assert property (p_cpu_write) else $error("CPU level write lost");

    property p_auto_ignores_write;
        @(posedge aclk) disable iff (!aresetn)
        s_cpr_write and cpr_reg[APSE_BIT] and !wdata_reg[APSE_BIT]
            |=> $stable(cpr_reg[CLVL_HI:CLVL_LO]);
    endproperty
    a_auto_ignores_write: assert property (p_auto_ignores_write) else $error("CPU level write not ignored");

    property p_mirror;
        @(posedge aclk) disable iff (!aresetn)
        cpr_reg[APSE_BIT] && $stable(mask_level) |=> cpr_reg[CLVL_HI:CLVL_LO] == $past(mask_level);
    endproperty
    a_mirror: assert property (p_mirror) else $error("CPU level not mirrored");

    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        !cpr_reg[APSE_BIT] && !wr_fire |=> $stable(cpr_reg[CLVL_HI:CLVL_LO]);
    endproperty
    a_hold: assert property (p_hold) else $error("CPU level changed without write");

    property p_mode0_map;
        @(posedge aclk) disable iff (!aresetn)
        cpr_reg[APSE_BIT] && !wr_fire && mode_reg == MODE_0
            |=> cpr_reg[CLVL_HI:CLVL_LO] == ($past(ccr_mask_bit) ? LVL_MAX : LVL_MIN);
    endproperty
    a_mode0_map: assert property (p_mode0_map) else $error("Mode 0 mask map wrong");

    property p_mode2_src;
        @(posedge aclk) disable iff (!aresetn)
        cpr_reg[APSE_BIT] && !wr_fire && mode_reg == MODE_2
            |=> cpr_reg[CLVL_HI:CLVL_LO] == $past(exr_mask_level);
    endproperty
    a_mode2_src: assert property (p_mode2_src) else $error("Mode 2 mask source wrong");

    property p_win;
        @(posedge aclk) disable iff (!aresetn)
        cpu_over_xfer |-> cpr_reg[CPCE_BIT] && cpr_reg[CLVL_HI:CLVL_LO] > cpr_reg[XLVL_HI:XLVL_LO];
    endproperty
    a_win: assert property (p_win) else $error("CPU won without higher level");
endmodule : cdp_priority_ctrl

// [verif/cdp_cpu_model.sv]
// Behavioural CPU core model that supplies the interrupt mask bit and mask level
`timescale 1ns/1ps
module cdp_cpu_model
    import cdp_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             step,
    output logic                  ccr_mask_bit,
    output logic      [LVL_W-1:0] exr_mask_level
);
    // New mask values only on request, so the bench knows when the mirror must move
    always @(posedge aclk) begin
        if (!aresetn) begin
            ccr_mask_bit   <= 1'b0;
            exr_mask_level <= LVL_MIN;
        end else if (step) begin
            ccr_mask_bit   <= 1'($urandom);
            exr_mask_level <= 3'($urandom);
        end
    end
endmodule : cdp_cpu_model

// [verif/tb_top.sv]
// Self-checking bench for the CPU / transfer priority control block
`timescale 1ns/1ps
module tb_top
    import cdp_pkg::*;
;
    logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, step;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata;
    wire logic         awready, wready, bvalid, arready, rvalid, over, mbit;
    wire logic [1:0]   bresp, rresp, mode;
    wire logic [31:0]  rdata;
    wire logic [2:0]   xlvl, clvl, mlvl;
    int                n_mismatch, compares;
    logic [33:0]       exp_q[$];
    logic [1:0]        expb_q[$];

    always #12.5 aclk = ~aclk;

    cdp_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .step(step), .ccr_mask_bit(mbit), .exr_mask_level(mlvl));

    cdp_priority_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ccr_mask_bit(mbit), .exr_mask_level(mlvl), .ctrl_mode(mode),
        .xfer_prio_level(xlvl), .cpu_prio_level(clvl), .cpu_over_xfer(over));

    task chk(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task summarize;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    task tmo;
        n_mismatch++;
        summarize();
    endtask : tmo

    // Handshakes are sampled at the falling edge, where every signal has settled
    task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        expb_q.push_back(er);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'($urandom), d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                return;
            end
        end
        tmo();
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tr;
        exp_q.push_back({er, 24'h0, d});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                return;
            end
        end
        tmo();
    endtask : rd

    always @(negedge aclk) begin
        if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
    end

    // Write responses are compared where bvalid and bready meet, like read data
    always @(negedge aclk) begin
        if (bvalid && bready) chk(34'(bresp), 34'(expb_q.pop_front()));
    end

    task lv(input logic [2:0] c, input logic [2:0] x, input logic o);
        @(negedge aclk);
        chk(34'(clvl), 34'(c));
        chk(34'(xlvl), 34'(x));
        chk(34'(over), 34'(o));
    endtask : lv

    task bump;
        step <= 1'b1;
        @(posedge aclk);
        step <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : bump

    task mir(input logic [1:0] m);
        logic [2:0] e;
        bump();
        e = (m == MODE_2) ? mlvl : {3{mbit}};
        lv(e, 3'h0, e > 3'h0);
    endtask : mir

    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, step} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        n_mismatch = 0;
        compares = 0;
        void'($urandom(32'h3316));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CPR_ADDR, CPR_RESET, RESP_OKAY);
        rd(CFG_ADDR, 8'h00, RESP_OKAY);
        rd(STA_ADDR, 8'h00, RESP_OKAY);
        for (int l = 0; l < 8; l++) begin
            wr(CPR_ADDR, {1'b1, 3'(l), 1'b0, 3'(7 - l)}, RESP_OKAY);
            rd(CPR_ADDR, {1'b1, 3'(l), 1'b0, 3'(7 - l)}, RESP_OKAY);
            rd(STA_ADDR, {4'h0, 1'((7 - l) > l), 3'(7 - l)}, RESP_OKAY);
            lv(3'(7 - l), 3'(l), (7 - l) > l);
        end
        wr(CPR_ADDR, 8'h07, RESP_OKAY);
        lv(3'h0, 3'h0, 1'b0);
        rd(CPR_ADDR, 8'h07, RESP_OKAY);
        wr(CPR_ADDR, 8'h88, RESP_OKAY);
        repeat (6) mir(MODE_0);
        wr(CPR_ADDR, 8'h8d, RESP_OKAY);
        rd(CPR_ADDR, {5'b10001, {3{mbit}}}, RESP_OKAY);
        wr(CFG_ADDR, {6'h0, MODE_2}, RESP_OKAY);
        wr(CFG_ADDR, 8'h01, RESP_OKAY);
        wr(CFG_ADDR, 8'h03, RESP_OKAY);
        rd(CFG_ADDR, {6'h0, MODE_2}, RESP_OKAY);
        chk(34'(mode), 34'(MODE_2));
        repeat (6) mir(MODE_2);
        wr(CPR_ADDR, 8'h80, RESP_OKAY);
        rd(CPR_ADDR, {5'b10000, mlvl}, RESP_OKAY);
        wr(CPR_ADDR, 8'h83, RESP_OKAY);
        bump();
        lv(3'h3, 3'h0, 1'b1);
        wr(4'hc, 8'hff, RESP_SLVERR);
        rd(4'hc, 8'h00, RESP_SLVERR);
        rd(CPR_ADDR, 8'h83, RESP_OKAY);
        // Reset in mid-run must bring every field and the mode back to zero
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CPR_ADDR, CPR_RESET, RESP_OKAY);
        rd(CFG_ADDR, 8'h00, RESP_OKAY);
        lv(3'h0, 3'h0, 1'b0);
        summarize();
    end
endmodule : tb_top
